// *** include/amf_pkg.sv ***
// Purpose: constants and types for converter input control and result format
// Assumes: 8-bit special function register space, 10-bit signed result
// Notes: field positions follow the input control byte
// Contract
// - Channel code and differential bit pick the positive and negative inputs.
// - Reference enable set feeds the temperature sensor as test input.
// - Reference enable clear feeds one eighth supply as test input.
// - Right justified, low byte holds result bits seven to zero.
// - Left justified, low byte holds result bits one, zero on top.
// - Right justified, high byte holds bits nine, eight, sign extended.
// - Left justified, high byte holds result bits nine to two.
// - Low result register at AC hex, resets to zero.
// - High result register at AD hex, resets to zero.
// - Reference enable picks internal reference, else supply reference.
// - Differential bit selects differential or single-ended decoding.
package amf_pkg;
  localparam int RES_W = 10;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  // Register addresses
  localparam logic [7:0] ADDR_INPUT_CTRL = 8'hA5;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hAC;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hAD;
  localparam logic [7:0] ADDR_FORMAT_CTRL = 8'hA6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Input control fields
  localparam int BIT_CONNECT = 7;
  localparam int BIT_INTERNAL_REFERENCE_ENABLE = 6;
  localparam int BIT_TRG_HI = 5;
  localparam int BIT_TRG_LO = 4;
  localparam int BIT_DIFFERENTIAL_ENABLE = 3;
  localparam int BIT_CHAN_HI = 2;
  localparam int BIT_CHAN_LO = 0;
  // Format control fields
  localparam int BIT_LEFT = 0;
  localparam int BIT_NEW = 7;
  localparam int LOW_LEFT_LSB = 6;
  localparam int HIGH_SIGN_BIT = 1;
  localparam int LEFT_SHIFT = 6;
  localparam logic [5:0] LOW_PAD = 6'h00;

  typedef enum logic [3:0] {
    AMF_POS_PIN0 = 4'h0,
    AMF_POS_PIN1 = 4'h1,
    AMF_POS_PIN2 = 4'h2,
    AMF_POS_PIN3 = 4'h3,
    AMF_POS_PIN4 = 4'h4,
    AMF_POS_PIN5 = 4'h5,
    AMF_POS_PIN6 = 4'h6,
    AMF_POS_TEST = 4'h7,
    AMF_POS_NONE = 4'hF
  } amf_pos_e;

  typedef enum logic [2:0] {
    AMF_NEG_HALF_VDD = 3'h0,
    AMF_NEG_VREF = 3'h1,
    AMF_NEG_PIN1 = 3'h2,
    AMF_NEG_PIN3 = 3'h3,
    AMF_NEG_PIN5 = 3'h4,
    AMF_NEG_NONE = 3'h7
  } amf_neg_e;

  typedef struct packed {
    amf_pos_e pos;
    amf_neg_e neg;
    logic legal;
  } amf_sel_s;
endpackage

// *** src/amf_top.sv ***
// Purpose: input selection and result formatting for the delta converter
// Assumes: core gives a one-cycle done pulse with a 10-bit signed result
// Notes: register reads answer one cycle after the read strobe
// Notes: format register at A6 holds justify and a new-result flag
// Notes: reserved differential codes leave the inputs disconnected
// Notes: a justify write reformats the stored result at once
`timescale 1ns/10ps
`default_nettype none
module amf_top
  (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Register port
  input wire logic [amf_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [amf_pkg::DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [amf_pkg::DATA_W-1:0] RDATA_OUT,
  // Converter core result
  input wire logic DONE_IN,
  input wire logic [amf_pkg::RES_W-1:0] RESULT_IN,
  // Analog multiplexer control
  output amf_pkg::amf_sel_s SEL_OUT,
  output logic CONNECT_OUT,
  output logic TEST_TEMP_OUT,
  output logic REF_INTERNAL_OUT,
  output logic DIFFERENTIAL_ENABLE_MODE_OUT,
  output logic [1:0] TRIGGER_SEL_OUT
  );

  // Stored state
  logic [amf_pkg::DATA_W-1:0] ctrl_q;
  logic left_q;
  logic new_q;
  logic [amf_pkg::RES_W-1:0] raw_q;
  logic [amf_pkg::DATA_W-1:0] low_q;
  logic [amf_pkg::DATA_W-1:0] high_q;

  // Formatting
  logic [amf_pkg::DATA_W-1:0] low_d;
  logic [amf_pkg::DATA_W-1:0] high_d;
  logic [amf_pkg::RES_W-1:0] fmt_src;
  logic fmt_left;
  logic fmt_load;

  // Register access
  logic [amf_pkg::DATA_W-1:0] rdata_d;
  logic [amf_pkg::DATA_W-1:0] fmt_rd;
  logic wr_ctrl;
  logic wr_fmt;
  logic rd_high;

  // Control field decode
  amf_pkg::amf_sel_s sel_d;
  logic [2:0] chan;
  logic differential_enable;
  logic conn_bit;
  logic internal_reference_enable_bit;
  logic [1:0] trig;

  // Register write and clearing read decode
  assign wr_ctrl = WR_IN && (ADDR_IN == amf_pkg::ADDR_INPUT_CTRL);
  assign wr_fmt = WR_IN && (ADDR_IN == amf_pkg::ADDR_FORMAT_CTRL);
  assign rd_high = RD_IN && (ADDR_IN == amf_pkg::ADDR_RESULT_HIGH);

  // Input control register
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      ctrl_q <= amf_pkg::RESET_BYTE;
    else if (wr_ctrl)
      ctrl_q <= WDATA_IN;
  end

  // Justification control
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      left_q <= 1'b0;
    else if (wr_fmt)
      left_q <= WDATA_IN[amf_pkg::BIT_LEFT];
  end

  // New result flag: a completion beats a clearing read
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      new_q <= 1'b0;
    else if (DONE_IN)
      new_q <= 1'b1;
    else if (rd_high)
      new_q <= 1'b0;
  end

  // Raw result kept so a change of justification can reformat it
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      raw_q <= '0;
    else if (DONE_IN)
      raw_q <= RESULT_IN;
  end

  // Fresh result in its done cycle, else the stored one
  always_comb
  begin
    fmt_src = DONE_IN ? RESULT_IN : raw_q;
    fmt_left = wr_fmt ? WDATA_IN[amf_pkg::BIT_LEFT] : left_q;
    fmt_load = DONE_IN || wr_fmt;
  end

  // Low result byte
  always_comb
  begin
    if (fmt_left)
      low_d = {fmt_src[amf_pkg::DATA_W-amf_pkg::LOW_LEFT_LSB-1:0],
               amf_pkg::LOW_PAD};
    else
      low_d = fmt_src[amf_pkg::DATA_W-1:0];
  end

  // High result byte; the register loop copies the sign upward
  always_comb
  begin
    high_d = amf_pkg::RESET_BYTE;
    if (fmt_left)
      high_d =
        fmt_src[amf_pkg::RES_W-1:amf_pkg::RES_W-amf_pkg::DATA_W];
    else
      high_d[amf_pkg::HIGH_SIGN_BIT:0] =
        fmt_src[amf_pkg::RES_W-1:amf_pkg::DATA_W];
  end

  // Result registers, loaded in the same cycle so the bytes always match
  genvar gi;
  generate
    for (gi = 0; gi < amf_pkg::DATA_W; gi = gi + 1)
    begin : g_low
      always_ff @(posedge CLK_IN)
      begin
        if (SRST_IN)
          low_q[gi] <= 1'b0;
        else if (fmt_load)
          low_q[gi] <= low_d[gi];
      end
    end
  endgenerate

  // Right justified: bits above the sign copy it
  generate
    for (gi = 0; gi < amf_pkg::DATA_W; gi = gi + 1)
    begin : g_high
      always_ff @(posedge CLK_IN)
      begin
        if (SRST_IN)
          high_q[gi] <= 1'b0;
        else if (fmt_load && !fmt_left && gi > amf_pkg::HIGH_SIGN_BIT)
          high_q[gi] <= high_d[amf_pkg::HIGH_SIGN_BIT];
        else if (fmt_load)
          high_q[gi] <= high_d[gi];
      end
    end
  endgenerate

  // Channel decode
  assign chan = ctrl_q[amf_pkg::BIT_CHAN_HI:amf_pkg::BIT_CHAN_LO];
  assign differential_enable = ctrl_q[amf_pkg::BIT_DIFFERENTIAL_ENABLE];
  assign conn_bit = ctrl_q[amf_pkg::BIT_CONNECT];
  assign internal_reference_enable_bit = ctrl_q[amf_pkg::BIT_INTERNAL_REFERENCE_ENABLE];
  assign trig = ctrl_q[amf_pkg::BIT_TRG_HI:amf_pkg::BIT_TRG_LO];

  always_comb
  begin
    sel_d.pos = amf_pkg::AMF_POS_NONE;
    sel_d.neg = amf_pkg::AMF_NEG_NONE;
    sel_d.legal = 1'b1;
    // Single-ended: pins against half supply, code 6 test input against reference
    if (!differential_enable)
    begin
      unique case (chan)
        3'h0:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN0;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h1:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN1;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h2:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN2;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h3:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN3;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h4:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN4;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h5:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN5;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
        3'h6:
        begin
          sel_d.pos = amf_pkg::AMF_POS_TEST;
          sel_d.neg = amf_pkg::AMF_NEG_VREF;
        end
        3'h7:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN6;
          sel_d.neg = amf_pkg::AMF_NEG_HALF_VDD;
        end
      endcase
    end
    else
    begin
      // Differential pairs; other codes reserved
      unique case (chan)
        3'h0:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN0;
          sel_d.neg = amf_pkg::AMF_NEG_PIN1;
        end
        3'h1:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN2;
          sel_d.neg = amf_pkg::AMF_NEG_PIN3;
        end
        3'h2:
        begin
          sel_d.pos = amf_pkg::AMF_POS_PIN4;
          sel_d.neg = amf_pkg::AMF_NEG_PIN5;
        end
        default:
          sel_d.legal = 1'b0;
      endcase
    end
  end

  // Multiplexer selection
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      SEL_OUT <= '{pos: amf_pkg::AMF_POS_PIN0,
                   neg: amf_pkg::AMF_NEG_HALF_VDD, legal: 1'b1};
    else
      SEL_OUT <= sel_d;
  end

  // Reserved codes leave the inputs open
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      CONNECT_OUT <= 1'b0;
    else
      CONNECT_OUT <= conn_bit && sel_d.legal;
  end

  // Temperature sensor when set, supply eighth when clear
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      TEST_TEMP_OUT <= 1'b0;
    else
      TEST_TEMP_OUT <= internal_reference_enable_bit;
  end

  // Internal or supply reference
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      REF_INTERNAL_OUT <= 1'b0;
    else
      REF_INTERNAL_OUT <= internal_reference_enable_bit;
  end

  // Differential decode mode
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      DIFFERENTIAL_ENABLE_MODE_OUT <= 1'b0;
    else
      DIFFERENTIAL_ENABLE_MODE_OUT <= differential_enable;
  end

  // Trigger source field
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      TRIGGER_SEL_OUT <= 2'h0;
    else
      TRIGGER_SEL_OUT <= trig;
  end

  // Format register readback
  always_comb
  begin
    fmt_rd = amf_pkg::RESET_BYTE;
    fmt_rd[amf_pkg::BIT_LEFT] = left_q;
    fmt_rd[amf_pkg::BIT_NEW] = new_q;
  end

  // Read mux; result bytes ignore writes
  always_comb
  begin
    rdata_d = amf_pkg::RESET_BYTE;
    if (RD_IN)
    begin
      unique case (ADDR_IN)
        amf_pkg::ADDR_INPUT_CTRL:
          rdata_d = ctrl_q;
        amf_pkg::ADDR_FORMAT_CTRL:
          rdata_d = fmt_rd;
        amf_pkg::ADDR_RESULT_LOW:
          rdata_d = low_q;
        amf_pkg::ADDR_RESULT_HIGH:
          rdata_d = high_q;
        default:
          rdata_d = amf_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      RDATA_OUT <= amf_pkg::RESET_BYTE;
    else
      RDATA_OUT <= rdata_d;
  end
endmodule
`default_nettype wire

// *** test/amf_asserts.sv ***
// Purpose: port checker for amf_top
// Assumes: strobes one cycle long, never together
// Notes: keeps its own copy of the stored result
`timescale 1ns/10ps
`default_nettype none
module amf_chk
  (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic DONE_IN,
  input wire logic [9:0] RESULT_IN,
  input wire amf_pkg::amf_sel_s SEL_OUT,
  input wire logic CONNECT_OUT,
  input wire logic TEST_TEMP_OUT,
  input wire logic REF_INTERNAL_OUT,
  input wire logic DIFFERENTIAL_ENABLE_MODE_OUT
  );
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  logic [9:0] raw_q;
  logic lj_q;
  logic [7:0] lo_exp;
  logic [7:0] hi_exp;
  logic [7:0] sel_exp;
  logic [2:0] ch;
  always_ff @(posedge CLK_IN)
    if (SRST_IN)
      raw_q <= 10'h000;
    else if (DONE_IN)
      raw_q <= RESULT_IN;
  always_ff @(posedge CLK_IN)
    if (SRST_IN)
      lj_q <= 1'b0;
    else if (WR_IN && ADDR_IN == amf_pkg::ADDR_FORMAT_CTRL)
      lj_q <= WDATA_IN[0];
  assign lo_exp = lj_q ? {raw_q[1:0], 6'h00} : raw_q[7:0];
  assign hi_exp = lj_q ? raw_q[9:2] : {{6{raw_q[9]}}, raw_q[9:8]};
  assign ch = WDATA_IN[2:0];
  // Expected selection, packed as pos, neg, legal
  always_comb
    if (WDATA_IN[3])
      sel_exp = ch < 3'h3 ? {1'b0, ch[1:0], 1'b0, ch + 3'h2, 1'b1} : 8'hFE;
    else if (ch == 3'h6)
      sel_exp = 8'h73;
    else if (ch == 3'h7)
      sel_exp = 8'h61;
    else
      sel_exp = {1'b0, ch, 4'h1};
  sequence s_ctl_wr;
    WR_IN && ADDR_IN == amf_pkg::ADDR_INPUT_CTRL;
  endsequence
  property p_sel;
    s_ctl_wr |-> ##2 SEL_OUT == $past(sel_exp, 2);
  endproperty
  a_sel: assert property (p_sel) else $error("mux select wrong");
  property p_conn;
    s_ctl_wr |-> ##2 CONNECT_OUT == $past(WDATA_IN[7] && sel_exp[0], 2);
  endproperty
  a_conn: assert property (p_conn) else $error("connect wrong");
  property p_temp;
    s_ctl_wr |-> ##2 TEST_TEMP_OUT == $past(WDATA_IN[6], 2);
  endproperty
  a_temp: assert property (p_temp) else $error("test input wrong");
  property p_ref;
    s_ctl_wr |-> ##2 REF_INTERNAL_OUT == $past(WDATA_IN[6], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_differential_enable;
    s_ctl_wr |-> ##2 DIFFERENTIAL_ENABLE_MODE_OUT == $past(WDATA_IN[3], 2);
  endproperty
  a_differential_enable: assert property (p_differential_enable) else $error("mode wrong");
  property p_lo;
    RD_IN && ADDR_IN == amf_pkg::ADDR_RESULT_LOW |=> RDATA_OUT == $past(lo_exp);
  endproperty
  a_lo: assert property (p_lo) else $error("low byte wrong");
  property p_hi;
    RD_IN && ADDR_IN == amf_pkg::ADDR_RESULT_HIGH |=> RDATA_OUT == $past(hi_exp);
  endproperty
  a_hi: assert property (p_hi) else $error("high byte wrong");
  property p_idle;
    !RD_IN |=> RDATA_OUT == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
endmodule
bind amf_top amf_chk u_chk (.*);
`default_nettype wire

// *** test/amf_core_model.sv ***
// Purpose: behavioural converter core feeding results
// Assumes: latency given per conversion, at least one
// Notes: result bus carries junk outside the done cycle
`timescale 1ns/10ps
`default_nettype none
module amf_core_model
  (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic go_in,
  input wire logic [3:0] lat_in,
  input wire logic [9:0] val_in,
  output logic done_out,
  output logic [9:0] result_out
  );
  logic [3:0] cnt_q;
  logic [9:0] val_q;
  always_ff @(posedge clk_in)
    if (srst_in)
      cnt_q <= 4'h0;
    else if (go_in)
      cnt_q <= lat_in;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  always_ff @(posedge clk_in)
    if (srst_in)
      val_q <= 10'h000;
    else if (go_in)
      val_q <= val_in;
  always_ff @(posedge clk_in)
    done_out <= !srst_in && cnt_q == 4'h1;
  always_ff @(posedge clk_in)
    result_out <= cnt_q == 4'h1 ? val_q : ~val_q;
endmodule
`default_nettype wire

// *** test/test_adc_mux_result_format.sv ***
// Purpose: register level test of amf_top
// Assumes: mux outputs settle two edges after a control write
// Notes: partner model supplies conversion results
`timescale 1ns/10ps
`default_nettype none
module test_adc_mux_result_format;
  logic clk = 1'b0;
  logic srst, wr_s, rd_s, done, go, conn, temp, ref_o, differential_enable_o;
  logic [7:0] addr, wdata, rdata, d, q;
  logic [1:0] trig;
  logic [9:0] result, val, v;
  logic [3:0] lat;
  amf_pkg::amf_sel_s sel;
  int n_errors = 0;
  int checks_done = 0;
  logic [9:0] vals [4] = '{10'h2C5, 10'h135, 10'h200, 10'h1FF};
  always #5 clk = ~clk;
  amf_top u_dut (.CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .DONE_IN(done), .RESULT_IN(result), .SEL_OUT(sel), .CONNECT_OUT(conn),
    .TEST_TEMP_OUT(temp), .REF_INTERNAL_OUT(ref_o),
    .DIFFERENTIAL_ENABLE_MODE_OUT(differential_enable_o), .TRIGGER_SEL_OUT(trig));
  amf_core_model u_core (.clk_in(clk), .srst_in(srst), .go_in(go),
    .lat_in(lat), .val_in(val), .done_out(done), .result_out(result));
  task automatic check(input string what, input logic [9:0] seen,
    input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic convert(input logic [9:0] x, input logic [3:0] l);
    @(posedge clk);
    go <= 1'b1;
    val <= x;
    lat <= l;
    @(posedge clk);
    go <= 1'b0;
    for (int n = 0; n < 20 && done !== 1'b1; n++)
      @(posedge clk);
    @(posedge clk);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    finish_test;
  end
  initial
  begin
    {srst, wr_s, rd_s, go, addr, wdata, val, lat} = {1'b1, 33'h0};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(amf_pkg::ADDR_RESULT_LOW);
    check("low reset", q, 10'h000);
    rd(amf_pkg::ADDR_RESULT_HIGH);
    check("high reset", q, 10'h000);
    rd(8'h10);
    check("unmapped", q, 10'h000);
    for (int i = 0; i < 32; i++)
    begin
      d = {1'b0, i[4], i[1:0], i[3:0]};
      wr(amf_pkg::ADDR_INPUT_CTRL, d);
      wr(amf_pkg::ADDR_INPUT_CTRL, d | 8'h80);
      repeat (2) @(posedge clk);
      #1;
      check("legal", sel.legal, !(d[3] && d[2:0] > 3'h2));
      check("connect", conn, !(d[3] && d[2:0] > 3'h2));
      check("temp", temp, d[6]);
      check("ref", ref_o, d[6]);
      check("differential_enable", differential_enable_o, d[3]);
      check("trigger", trig, d[5:4]);
    end
    foreach (vals[k])
      for (int j = 0; j < 2; j++)
      begin
        v = vals[k];
        wr(amf_pkg::ADDR_FORMAT_CTRL, {7'h00, j[0]});
        convert(v, 4'(k * 3 + 1));
        rd(amf_pkg::ADDR_FORMAT_CTRL);
        check("format new", q, {3'h0, 1'b1, 6'h00, j[0]});
        wr(amf_pkg::ADDR_RESULT_LOW, 8'h5A);
        rd(amf_pkg::ADDR_RESULT_LOW);
        check("low", q, j[0] ? {v[1:0], 6'h00} : v[7:0]);
        rd(amf_pkg::ADDR_RESULT_HIGH);
        check("high", q, j[0] ? v[9:2] : {{6{v[9]}}, v[9:8]});
        rd(amf_pkg::ADDR_FORMAT_CTRL);
        check("format clear", q, {9'h000, j[0]});
      end
    finish_test;
  end
endmodule
`default_nettype wire
